// ==== pse_map.vh ====
// Purpose: register offsets, field positions, reset values and timing
//          constants for the port control and watchdog register group
// Assumes: byte-wide registers on the serial register engine port
// Notes:   definitions only
`ifndef PSE_MAP_VH
`define PSE_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PSE_OFF_MODE        8'h12
`define PSE_OFF_TIMING      8'h16
`define PSE_OFF_MISC        8'h17
`define PSE_OFF_PWR_BTN     8'h19
`define PSE_OFF_GLB_BTN     8'h1a
`define PSE_OFF_IDENT       8'h1b
`define PSE_OFF_TAKEOVER    8'h1c
`define PSE_OFF_WD_COUNT    8'h1e
`define PSE_OFF_WD_CFG      8'h1f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSE_RST_TIMING      8'h00
`define PSE_RST_MISC        8'hc0
`define PSE_RST_TAKEOVER    4'h0
`define PSE_RST_WD_COUNT    8'h00
`define PSE_RST_WD_CFG      8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PSE_MISC_IRQ_OUT_EN 7
`define PSE_MISC_RESTART_EN 6
`define PSE_MISC_CLS_BLOCK  3
`define PSE_MISC_CLS_CUT    2
`define PSE_MISC_DET_ISO    1
`define PSE_MISC_WR_MASK    8'h86
`define PSE_GLB_IRQ_CLR     7
`define PSE_GLB_CHIP_RST    4
`define PSE_WD_EN           7
`define PSE_WD_CFG_WR_MASK  8'hdf
`define PSE_TIM_RESTART_HI  7
`define PSE_TIM_START_HI    5
`define PSE_TIM_FAULT_HI    3
`define PSE_TIM_DISC_HI     1

// ----------------------------------------------------------------
// port mode codes
// ----------------------------------------------------------------
`define PSE_MODE_SHDN       2'b00
`define PSE_MODE_MANUAL     2'b01
`define PSE_MODE_SEMI       2'b10
`define PSE_MODE_AUTO       2'b11

// ----------------------------------------------------------------
// timing: nominal windows in microseconds, watchdog step
// ----------------------------------------------------------------
`define PSE_TFAULT_NOM_US   60000
`define PSE_TSTART_NOM_US   60000
`define PSE_DISCONNECT_TIME_SCALE_NOM_US    350000
`define PSE_WD_STEP_MS      164
`define PSE_CLK_MHZ         125
`define PSE_WD_STEP_CYC     (`PSE_WD_STEP_MS * 1000 * `PSE_CLK_MHZ)

`endif

// ==== pse_ctrl_regs.v ====
// Purpose: port control, pushbutton, identification, hardware takeover
//          and watchdog register group of a four-port PoE source controller
// Assumes: a serial register engine delivers byte reads and writes as
//          one-cycle strobes; analog port state arrives as synchronous levels
// Notes:   read data is registered one cycle after the read strobe
//
// How it works
// - startup and fault windows: 60ms nominal, half, double or quadruple by code.
// - disconnect window: 350ms nominal, quarter, half or double by code.
// - restart off time is 16, 32, 64 or 0 fault times when hold enabled.
// - class current cut lowers each port fault limit by its class result.
// - raised high-power current applies only after a port started up normally.
// - detect isolation bit puts all detect pins into high impedance.
// - misc configuration resets to c0: irq output and restart hold enabled.
// - read-only block bit stops auto power-up after class failure over 50mA.
// - power buttons act in semi and manual modes; power-on ignored in auto.
// - on ignored if powered, off ignored if off, both ignored in shutdown.
// - power and global button bits clear themselves after execution.
// - power-on during detection or classification aborts it and powers in the same cycle.
// - irq clear button clears all event registers and interrupt bits.
// - port soft reset removes power and clears only that port's status.
// - chip reset button returns the whole register map to reset state.
// - identification returns part code in 7:3, revision in 2:0, read-only.
// - watchdog expiry sets every port's takeover flag on entering hw mode.
// - hw mode refuses power-on and mode writes, flagging each refused power-on.
// - takeover flags in 3:0 clear on read and reset to zero.
// - enabled watchdog count decrements every 164ms down to zero.
// - expiry enters hw mode and moves ports to their selected expiry mode.
// - expiry select low writes mode 00, high writes mode 11.
// - port soft reset leaves the mode register unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "pse_map.vh"

module pse_ctrl_regs #(
    parameter [4:0] PART_CODE = 5'h0a,  // arbitrary value
    parameter [2:0] REV_CODE = 3'h1,    // arbitrary value
    parameter integer WD_STEP_CYC = `PSE_WD_STEP_CYC
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // register engine
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_r,
    // straps
    input wire auto_strap,
    // per-port analog state
    input wire [3:0] port_busy_det,
    input wire [3:0] auto_power_req,
    input wire [3:0] class_overcurrent,
    input wire [3:0] overcurrent_trip,
    input wire [3:0] startup_done,
    input wire [3:0] high_power_req,
    input wire [11:0] port_class,
    // port control
    output reg [3:0] port_power_en_r,
    output reg [3:0] det_abort_r,
    output reg [3:0] port_soft_reset_r,
    output reg [3:0] high_power_apply_r,
    output reg [11:0] fault_limit_threshold_r,
    output reg [3:0] fault_limit_cut_r,
    output reg [7:0] port_mode_r,
    output reg detect_pin_hiz_r,
    output reg irq_out_en_r,
    output reg event_clear_r,
    output reg chip_reset_r,
    output reg hw_mode_r,
    // timing windows in microseconds
    output reg [17:0] start_time_us_r,
    output reg [17:0] fault_time_us_r,
    output reg [19:0] disc_time_us_r,
    output reg [23:0] restart_off_us_r
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    reg [7:0] timing_r;
    reg [7:0] misc_r;
    reg [7:0] pwr_btn_r;
    reg [3:0] takeover_r;
    reg [7:0] watchdog_count;
    reg [7:0] wd_cfg_r;
    reg [31:0] wd_tick_r;
    reg irq_btn_r;
    reg [3:0] prst_btn_r;

    // chip soft reset restarts everything but the reset pulse itself
    wire rst_all = !nrst || chip_reset_r;

    wire wr_mode = reg_wr && (reg_addr == `PSE_OFF_MODE);
    wire wr_timing = reg_wr && (reg_addr == `PSE_OFF_TIMING);
    wire wr_misc = reg_wr && (reg_addr == `PSE_OFF_MISC);
    wire wr_pwr = reg_wr && (reg_addr == `PSE_OFF_PWR_BTN);
    wire wr_glb = reg_wr && (reg_addr == `PSE_OFF_GLB_BTN);
    wire wr_wdc = reg_wr && (reg_addr == `PSE_OFF_WD_COUNT);
    wire wr_wdg = reg_wr && (reg_addr == `PSE_OFF_WD_CFG);
    wire rd_take = reg_rd && (reg_addr == `PSE_OFF_TAKEOVER);

    wire wd_en = wd_cfg_r[`PSE_WD_EN];
    wire wd_tick = (wd_tick_r == WD_STEP_CYC - 1);
    // a zero count with the watchdog armed is expiry, also if armed at zero
    wire wd_expire = wd_en && (watchdog_count == 8'h00) && !hw_mode_r;

    wire [3:0] refused;
    wire [7:0] expiry_mode;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rst_all)
        begin
            timing_r <= `PSE_RST_TIMING;
            misc_r <= `PSE_RST_MISC;
            wd_cfg_r <= `PSE_RST_WD_CFG;
            port_mode_r <= {8{auto_strap}};
        end
        else
        begin
            if (wr_timing)
                timing_r <= reg_wdata;
            // restart hold and class block bits are read-only
            if (wr_misc)
                misc_r <= (misc_r & ~`PSE_MISC_WR_MASK) | (reg_wdata & `PSE_MISC_WR_MASK);
            if (wr_wdg)
                wd_cfg_r <= reg_wdata & `PSE_WD_CFG_WR_MASK;
            if (wd_expire)
                port_mode_r <= expiry_mode;
            else if (wr_mode && !hw_mode_r)
                port_mode_r <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rst_all)
        begin
            watchdog_count <= `PSE_RST_WD_COUNT;
            wd_tick_r <= 32'h0000_0000;
            hw_mode_r <= 1'b0;
        end
        else
        begin
            if (!wd_en || wr_wdc || wd_tick)
                wd_tick_r <= 32'h0000_0000;
            else
                wd_tick_r <= wd_tick_r + 32'h0000_0001;
            if (wr_wdc)
                watchdog_count <= reg_wdata;
            else if (wd_en && wd_tick && watchdog_count != 8'h00)
                watchdog_count <= watchdog_count - 8'h01;
            // hardware keeps control until software rearms or disarms
            if (wd_expire)
                hw_mode_r <= 1'b1;
            else if ((wr_wdc && reg_wdata != 8'h00) || !wd_en)
                hw_mode_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // takeover flags, set wins over clear-on-read
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rst_all)
            takeover_r <= `PSE_RST_TAKEOVER;
        else
            takeover_r <= (rd_take ? 4'h0 : takeover_r)
                | {4{wd_expire}}
                | refused;
    end

    // ----------------------------------------------------------------
    // pushbuttons: latched one cycle, executed, then cleared
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rst_all)
        begin
            pwr_btn_r <= 8'h00;
            irq_btn_r <= 1'b0;
            prst_btn_r <= 4'h0;
            event_clear_r <= 1'b0;
            port_soft_reset_r <= 4'h0;
        end
        else
        begin
            pwr_btn_r <= wr_pwr ? reg_wdata : 8'h00;
            irq_btn_r <= wr_glb && reg_wdata[`PSE_GLB_IRQ_CLR];
            prst_btn_r <= wr_glb ? reg_wdata[3:0] : 4'h0;
            event_clear_r <= irq_btn_r;
            port_soft_reset_r <= prst_btn_r;
        end
    end

    always @(posedge clk)
    begin
        if (!nrst)
            chip_reset_r <= 1'b0;
        else
            chip_reset_r <= wr_glb && reg_wdata[`PSE_GLB_CHIP_RST] && !chip_reset_r;
    end

    // ----------------------------------------------------------------
    // per-port power control
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_port
            wire [1:0] mode = port_mode_r[2*i+1:2*i];
            wire on_req = pwr_btn_r[i];
            wire off_req = pwr_btn_r[i+4];
            wire pwr = port_power_en_r[i];
            wire active = (mode == `PSE_MODE_MANUAL) || (mode == `PSE_MODE_SEMI);
            wire on_ok = on_req && active && !pwr && !hw_mode_r;
            wire off_ok = off_req && active && pwr;
            wire cls_blk = misc_r[`PSE_MISC_CLS_BLOCK] && class_overcurrent[i];
            wire auto_on = (mode == `PSE_MODE_AUTO) && auto_power_req[i] && !cls_blk;
            wire kill = overcurrent_trip[i] || prst_btn_r[i] || (mode == `PSE_MODE_SHDN);

            // a refused power-on in hardware mode is flagged whatever the mode
            assign refused[i] = on_req && hw_mode_r;
            assign expiry_mode[2*i+1:2*i] = wd_cfg_r[i] ? `PSE_MODE_AUTO : `PSE_MODE_SHDN;

            always @(posedge clk)
            begin
                if (rst_all)
                begin
                    port_power_en_r[i] <= 1'b0;
                    det_abort_r[i] <= 1'b0;
                    high_power_apply_r[i] <= 1'b0;
                end
                else
                begin
                    if (kill || off_ok)
                        port_power_en_r[i] <= 1'b0;
                    else if (on_ok || auto_on)
                        port_power_en_r[i] <= 1'b1;
                    det_abort_r[i] <= on_ok && port_busy_det[i];
                    // ports come up as plain devices before the raised limit
                    high_power_apply_r[i] <= high_power_req[i] && startup_done[i]
                        && pwr && !kill;
                end
            end

            always @(posedge clk)
            begin
                if (rst_all)
                begin
                    fault_limit_cut_r[i] <= 1'b0;
                    fault_limit_threshold_r[3*i+2:3*i] <= 3'h0;
                end
                else
                begin
                    fault_limit_cut_r[i] <= misc_r[`PSE_MISC_CLS_CUT];
                    fault_limit_threshold_r[3*i+2:3*i] <= misc_r[`PSE_MISC_CLS_CUT]
                        ? port_class[3*i+2:3*i] : 3'h0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // timing windows and misc outputs
    // ----------------------------------------------------------------
    function [17:0] scale_60;
        input [1:0] code;
        reg [17:0] nom;
        begin
            nom = 18'd60000;
            case (code)
                2'b00: scale_60 = nom;
                2'b01: scale_60 = nom >> 1;
                2'b10: scale_60 = nom << 1;
                2'b11: scale_60 = nom << 2;
                default: scale_60 = nom;
            endcase
        end
    endfunction

    wire [1:0] restart_code = timing_r[`PSE_TIM_RESTART_HI -: 2];
    wire [1:0] disc_code = timing_r[`PSE_TIM_DISC_HI -: 2];
    wire [17:0] fault_us = scale_60(timing_r[`PSE_TIM_FAULT_HI -: 2]);
    reg [19:0] disc_us;
    reg [23:0] restart_us;

    always @*
    begin
        case (disc_code)
            2'b00: disc_us = 20'd350000;
            2'b01: disc_us = 20'd87500;
            2'b10: disc_us = 20'd175000;
            2'b11: disc_us = 20'd700000;
            default: disc_us = 20'd350000;
        endcase
        case (restart_code)
            2'b00: restart_us = {6'h00, fault_us} << 4;
            2'b01: restart_us = {6'h00, fault_us} << 5;
            2'b10: restart_us = {6'h00, fault_us} << 6;
            2'b11: restart_us = 24'h000000;
            default: restart_us = 24'h000000;
        endcase
        if (!misc_r[`PSE_MISC_RESTART_EN])
            restart_us = 24'h000000;
    end

    always @(posedge clk)
    begin
        if (rst_all)
        begin
            start_time_us_r <= 18'd60000;
            fault_time_us_r <= 18'd60000;
            disc_time_us_r <= 20'd350000;
            restart_off_us_r <= 24'h000000;
            detect_pin_hiz_r <= 1'b0;
            irq_out_en_r <= 1'b0;
        end
        else
        begin
            start_time_us_r <= scale_60(timing_r[`PSE_TIM_START_HI -: 2]);
            fault_time_us_r <= fault_us;
            disc_time_us_r <= disc_us;
            restart_off_us_r <= restart_us;
            detect_pin_hiz_r <= misc_r[`PSE_MISC_DET_ISO];
            irq_out_en_r <= misc_r[`PSE_MISC_IRQ_OUT_EN];
        end
    end

    // ----------------------------------------------------------------
    // read path; write-only buttons and unmapped offsets read zero
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rst_all)
            reg_rdata_r <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `PSE_OFF_MODE: reg_rdata_r <= port_mode_r;
                `PSE_OFF_TIMING: reg_rdata_r <= timing_r;
                `PSE_OFF_MISC: reg_rdata_r <= misc_r;
                `PSE_OFF_IDENT: reg_rdata_r <= {PART_CODE, REV_CODE};
                `PSE_OFF_TAKEOVER: reg_rdata_r <= {4'h0, takeover_r};
                `PSE_OFF_WD_COUNT: reg_rdata_r <= watchdog_count;
                `PSE_OFF_WD_CFG: reg_rdata_r <= wd_cfg_r;
                default: reg_rdata_r <= 8'h00;
            endcase
        end
    end

endmodule // pse_ctrl_regs
`default_nettype wire

// ==== pse_regs_sva.sv ====
// Purpose: checker for the port control and watchdog register group
// Assumes: one clock, synchronous active-low reset
// Notes: button actions land within two edges of the write
`timescale 1ns/100ps
`default_nettype none
module pse_regs_sva #(
    parameter [4:0] PART_CODE = 5'h0a,
    parameter [2:0] REV_CODE = 3'h1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register engine
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata_r,
    // port control
    input wire logic [3:0] port_power_en_r,
    input wire logic [3:0] port_soft_reset_r,
    input wire logic [11:0] fault_limit_threshold_r,
    input wire logic [3:0] fault_limit_cut_r,
    input wire logic [7:0] port_mode_r,
    input wire logic irq_out_en_r,
    input wire logic event_clear_r,
    input wire logic chip_reset_r,
    input wire logic [17:0] start_time_us_r,
    input wire logic [17:0] fault_time_us_r,
    input wire logic [19:0] disc_time_us_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire glb_wr;
    assign glb_wr = reg_wr && reg_addr == 8'h1a;

    ident_read_a: assert property (
        reg_rd && reg_addr == 8'h1b |=> reg_rdata_r == {PART_CODE, REV_CODE})
        else $error("identification read wrong");
    soft_reset_a: assert property (
        glb_wr && reg_wdata[0] |-> ##[1:2] port_soft_reset_r[0] ##[0:1] !port_power_en_r[0])
        else $error("port soft reset missing or power kept");
    irq_clear_a: assert property (
        glb_wr && reg_wdata[7] |-> ##[1:2] event_clear_r ##1 !event_clear_r)
        else $error("event clear pulse wrong");
    chip_reset_a: assert property (
        glb_wr && reg_wdata[4] |-> ##[1:2] chip_reset_r)
        else $error("chip reset pulse missing");
    misc_reset_a: assert property (
        $rose(nrst) |-> ##[0:1] irq_out_en_r)
        else $error("irq output enable not set after reset");
    timing_codes_a: assert property (
        start_time_us_r inside {18'h0ea60, 18'h07530, 18'h1d4c0, 18'h3a980} &&
        fault_time_us_r inside {18'h0ea60, 18'h07530, 18'h1d4c0, 18'h3a980})
        else $error("startup or fault window off scale");
    disc_codes_a: assert property (
        disc_time_us_r inside {20'h55730, 20'h155cc, 20'h2ab98, 20'haae60})
        else $error("disconnect window off scale");
    cut_off_a: assert property (
        fault_limit_cut_r == 4'h0 |-> fault_limit_threshold_r == 12'h000)
        else $error("limit lowered without class cut");
    shdn_off_a: assert property (
        port_mode_r[1:0] == 2'b00 [*3] |-> !port_power_en_r[0])
        else $error("port powered in shutdown");
endmodule // pse_regs_sva
bind pse_ctrl_regs pse_regs_sva #(.PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) chk_u (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .port_power_en_r(port_power_en_r),
    .port_soft_reset_r(port_soft_reset_r), .fault_limit_threshold_r(fault_limit_threshold_r),
    .fault_limit_cut_r(fault_limit_cut_r), .port_mode_r(port_mode_r),
    .irq_out_en_r(irq_out_en_r), .event_clear_r(event_clear_r), .chip_reset_r(chip_reset_r),
    .start_time_us_r(start_time_us_r), .fault_time_us_r(fault_time_us_r),
    .disc_time_us_r(disc_time_us_r)
);
`default_nettype wire

// ==== pse_host_model.sv ====
// Purpose: host side of the register engine, byte reads and writes
// Assumes: requests launch 1 ns after a rising edge
// Notes: released lines show the inverse so stale values are never trusted
`timescale 1ns/100ps
`default_nettype none
module pse_host_model (
    // clock
    input wire logic clk,
    // register engine
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    input wire logic [7:0] reg_rdata_r
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        d = reg_rdata_r;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
    // a healthy host never lets the countdown reach zero
    task kick(input logic [7:0] n);
        wr(8'h1e, (n == 8'h00) ? 8'h01 : n);
    endtask
endmodule // pse_host_model
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench for the port control and watchdog registers
// Assumes: watchdog step shortened to STEP cycles
// Notes: fixed seed, corner cases mixed with random bytes
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam integer STEP = 16;
    localparam [4:0] PART = 5'h0a; // arbitrary value
    localparam [2:0] REV = 3'h5; // arbitrary value
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] port_busy_det = 4'h0;
    logic [3:0] startup_done = 4'h0, overcurrent_trip = 4'h0;
    logic [3:0] high_power_req = 4'h0;
    logic [11:0] port_class = 12'h000;
    wire [7:0] reg_addr, reg_wdata, reg_rdata_r, port_mode_r;
    wire reg_wr, reg_rd, detect_pin_hiz_r, event_clear_r, chip_reset_r, hw_mode_r;
    wire [3:0] port_power_en_r, det_abort_r, port_soft_reset_r, high_power_apply_r;
    wire [3:0] fault_limit_cut_r;
    wire irq_out_en_r;
    wire [11:0] fault_limit_threshold_r;
    wire [17:0] start_time_us_r, fault_time_us_r;
    wire [19:0] disc_time_us_r;
    wire [23:0] restart_off_us_r;
    integer seed = 53, bad_count = 0, n_compared = 0, i, n;
    logic [7:0] d, w;
    logic [7:0] mtab [4] = '{8'h55, 8'h55, 8'h5d, 8'h51};
    logic [7:0] btab [4] = '{8'h02, 8'h20, 8'h02, 8'h02};
    logic [3:0] ptab [4] = '{4'h2, 4'h0, 4'h0, 4'h0};

    pse_ctrl_regs #(.PART_CODE(PART), .REV_CODE(REV), .WD_STEP_CYC(STEP)) dut_u (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .auto_strap(1'b0),
        .port_busy_det(port_busy_det), .auto_power_req(4'h0), .class_overcurrent(4'h0),
        .overcurrent_trip(overcurrent_trip), .startup_done(startup_done),
        .high_power_req(high_power_req),
        .port_class(port_class), .port_power_en_r(port_power_en_r),
        .det_abort_r(det_abort_r), .port_soft_reset_r(port_soft_reset_r),
        .high_power_apply_r(high_power_apply_r), .fault_limit_cut_r(fault_limit_cut_r),
        .fault_limit_threshold_r(fault_limit_threshold_r), .port_mode_r(port_mode_r),
        .detect_pin_hiz_r(detect_pin_hiz_r), .irq_out_en_r(irq_out_en_r),
        .event_clear_r(event_clear_r),
        .chip_reset_r(chip_reset_r), .hw_mode_r(hw_mode_r), .start_time_us_r(start_time_us_r),
        .fault_time_us_r(fault_time_us_r), .disc_time_us_r(disc_time_us_r),
        .restart_off_us_r(restart_off_us_r)
    );
    pse_host_model hm_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));

    initial forever #4 clk = ~clk;

    function [31:0] sf_us(input [1:0] c);
        sf_us = (c == 2'h0) ? 32'h0ea60 : (c == 2'h1) ? 32'h07530 :
            (c == 2'h2) ? 32'h1d4c0 : 32'h3a980;
    endfunction
    function [31:0] disc_us(input [1:0] c);
        disc_us = (c == 2'h0) ? 32'h55730 : (c == 2'h1) ? 32'h155cc :
            (c == 2'h2) ? 32'h2ab98 : 32'haae60;
    endfunction
    function [31:0] rst_us(input [1:0] c);
        rst_us = (c == 2'h3) ? 32'h0 : (32'h10 << c) * sf_us(c);
    endfunction
    function logic pick(input integer s);
        case (s)
            0: pick = det_abort_r[1];
            1: pick = port_soft_reset_r[0];
            2: pick = event_clear_r;
            3: pick = chip_reset_r;
            default: pick = hw_mode_r;
        endcase
    endfunction
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk_rd(input logic [7:0] got, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_out(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        hm_u.rd(a, d);
        chk_rd(d, e);
    endtask
    task await(input integer s, input integer lim, output integer c);
        c = 0;
        while (pick(s) !== 1'b1 && c < lim)
        begin
            @(posedge clk);
            #1;
            c = c + 1;
        end
        if (c >= lim)
        begin
            bad_count = bad_count + 1;
            final_report;
        end
    endtask
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        rdc(8'h17, 8'hc0);
        rdc(8'h1e, 8'h00);
        rdc(8'h1c, 8'h00);
        hm_u.wr(8'h1b, 8'hff);
        rdc(8'h1b, {PART, REV});
        rdc(8'h40, 8'h00);
        for (i = 0; i < 4; i = i + 1)
        begin
            hm_u.wr(8'h16, {4{i[1:0]}});
            settle;
            chk_out(32'(start_time_us_r), sf_us(i[1:0]));
            chk_out(32'(fault_time_us_r), sf_us(i[1:0]));
            chk_out(32'(disc_time_us_r), disc_us(i[1:0]));
            chk_out(32'(restart_off_us_r), rst_us(i[1:0]));
        end
        for (i = 0; i < 5; i = i + 1)
        begin
            w = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            port_class = 12'($random(seed));
            high_power_req = 4'($random(seed));
            hm_u.wr(8'h17, w);
            rdc(8'h17, 8'h40 | (w & 8'h86));
            chk_out(32'({irq_out_en_r, fault_limit_cut_r, detect_pin_hiz_r}),
                32'({w[7], {4{w[2]}}, w[1]}));
            chk_out(32'(fault_limit_threshold_r), w[2] ? 32'(port_class) : 32'h0);
            chk_out(32'(high_power_apply_r), 32'h0);
        end
        port_busy_det = 4'h2;
        hm_u.wr(8'h12, 8'h55);
        hm_u.wr(8'h19, 8'h02);
        await(0, 6, n);
        rdc(8'h19, 8'h00);
        for (i = 0; i < 4; i = i + 1)
        begin
            hm_u.wr(8'h12, mtab[i]);
            hm_u.wr(8'h19, btab[i]);
            settle;
            chk_out(32'(port_power_en_r), 32'(ptab[i]));
        end
        hm_u.wr(8'h19, 8'h01);
        settle;
        startup_done = 4'h1;
        high_power_req = 4'h1;
        settle;
        chk_out(32'({high_power_apply_r, port_power_en_r}), 32'h11);
        overcurrent_trip = 4'h1;
        settle;
        chk_out(32'(port_power_en_r), 32'h0);
        overcurrent_trip = 4'h0;
        hm_u.wr(8'h19, 8'h01);
        settle;
        hm_u.wr(8'h1a, 8'h01);
        await(1, 6, n);
        settle;
        chk_out(32'(port_power_en_r), 32'h0);
        rdc(8'h12, 8'h51);
        hm_u.wr(8'h1a, 8'h80);
        await(2, 6, n);
        hm_u.kick(8'h03);
        hm_u.wr(8'h1f, 8'h85);
        await(4, 4 * STEP, n);
        chk_out(32'(n > 2 * STEP - 4), 32'h1);
        chk_out(32'(port_mode_r), 32'h33);
        rdc(8'h1c, 8'h0f);
        hm_u.wr(8'h12, 8'h55);
        rdc(8'h12, 8'h33);
        hm_u.wr(8'h19, 8'h02);
        rdc(8'h1c, 8'h02);
        hm_u.wr(8'h1f, 8'h00);
        hm_u.kick(8'h40);
        rdc(8'h1e, 8'h40);
        repeat (3 * STEP) @(posedge clk);
        rdc(8'h1e, 8'h40);
        hm_u.wr(8'h17, 8'h86);
        hm_u.wr(8'h1a, 8'h10);
        await(3, 6, n);
        settle;
        rdc(8'h17, 8'hc0);
        rdc(8'h12, 8'h00);
        final_report;
    end
endmodule // testbench
`default_nettype wire
